// >>> term_timing_pkg.sv
// Purpose: shared constants for the termination timing ends
// Assumes: single 25 MHz system clock
// Notes:   counts derived from printed times at 40 ns period
package term_timing_pkg;
	// ---------------------------------------------
	// clock
	// ---------------------------------------------
	localparam int CLK_PERIOD_PS = 40000;              // 25 MHz
	// ---------------------------------------------
	// delays in clocks
	// ---------------------------------------------
	localparam int TERM_ON_DELAY_CK   = 2;             // term_on_delay
	localparam int TERM_OFF_DELAY_HALF = 5;            // term_off_delay, 2.5 clocks as half cycles
	localparam int HIGH_PHASE_PERMILLE = 500;          // assumed high phase 0.5
	localparam int TERM_TO_PD_ENTRY_CK = 3;            // term_to_pd_entry_latency
	localparam int TERM_PD_EXIT_CK     = 8;            // term_pd_exit_latency
	localparam int WRITE_TO_READ_CK    = 2;            // write_to_read_delay floor
	localparam int FAST_EXIT_READ_CK   = 2;            // fast power-down exit
	localparam int SLOW_EXIT_BASE_CK   = 8;            // slow exit is this minus additive latency
	// ---------------------------------------------
	// times in ps and derived counts
	// ---------------------------------------------
	localparam int PD_MIN_EXTRA_PS   = 2000;           // power-down async min extra
	localparam int PD_MAX_EXTRA_PS   = 1000;           // power-down async max extra
	localparam int MODE_UPDATE_PS    = 12000;          // mode_to_term_update_delay
	localparam int IMP_TEST_PS       = 12000;          // impedance_test_driver_delay
	localparam int PD_MIN_CK = (PD_MIN_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MODE_UPDATE_CK_RAW = MODE_UPDATE_PS / CLK_PERIOD_PS;
	localparam int MODE_UPDATE_CK = (MODE_UPDATE_CK_RAW < 1) ? 1 : MODE_UPDATE_CK_RAW;
	localparam int IMP_TEST_CK_RAW = IMP_TEST_PS / CLK_PERIOD_PS;
	localparam int IMP_TEST_CK = (IMP_TEST_CK_RAW < 1) ? 1 : IMP_TEST_CK_RAW;
	// ---------------------------------------------
	// mode register fields
	// ---------------------------------------------
	localparam int MODE_EXIT_SEL_BIT = 12;             // A12 exit timing select
	localparam int EXT_RTT_HI_BIT    = 6;              // A6
	localparam int EXT_RTT_LO_BIT    = 2;              // A2
	localparam logic [1:0] RTT_OFF = 2'h0;
	localparam logic [1:0] RTT_75  = 2'h1;
	localparam logic [1:0] RTT_150 = 2'h2;
	localparam logic [1:0] RTT_50  = 2'h3;
	localparam logic [2:0] CMD_NOP  = 3'h0;
	localparam logic [2:0] CMD_MODE = 3'h1;            // mode_register_write
	localparam logic [2:0] CMD_EXT  = 3'h2;            // extended_mode_register_write
	localparam logic [2:0] CMD_WRITE_AP = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h4;
	localparam logic [2:0] CMD_WRITE = 3'h5;
	localparam logic [2:0] CMD_IMP_TEST = 3'h6;
	localparam int ADDR_W = 13;
	localparam int CNT_W  = 8;
	localparam logic [3:0] RESET_WR = 4'h2;            // write recovery reset
	localparam logic [2:0] RESET_AL = 3'h0;

	// decode A6,A2 into strength code
	function automatic logic [1:0] rtt_decode(input logic [ADDR_W-1:0] a);
		rtt_decode = {a[EXT_RTT_HI_BIT], a[EXT_RTT_LO_BIT]};
	endfunction
endpackage

// >>> term_link_if.sv
`timescale 1ns/100ps
// Purpose: command and termination link between controller and device
// Assumes: one clock shared by both ends
// Notes:   no clocking block
interface term_link_if;
	import term_timing_pkg::*;
	logic              cke;                 // clock enable
	logic              termination_control; // termination request
	logic [2:0]        cmd;                 // command code
	logic [ADDR_W-1:0] addr;                // address bits
	logic [1:0]        rtt_active;          // applied termination
	logic              imp_test_drive;      // test driver state
	modport device (input cke, termination_control, cmd, addr, output rtt_active, imp_test_drive);
	modport controller (output cke, termination_control, cmd, addr, input rtt_active, imp_test_drive);
endinterface

// >>> term_device.sv
// Purpose: device end, termination timing and mode state
// Assumes: link inputs come from logic on the same clock
// Notes:   half-cycle delays resolved to whole system cycles
`timescale 1ns/100ps
module term_device
	import term_timing_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  sys_rst,
	term_link_if.device link,
	output logic [1:0] rtt_setting,   // programmed strength
	output logic       slow_exit,     // exit timing select
	output logic       term_on        // termination enabled
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		logic [4:0]  pipe;       // sampled control, one bit per clock cycle step
		logic        on;         // termination applied
		logic [1:0]  rtt;        // programmed strength
		logic        slow;       // slow exit chosen
		logic [CNT_W-1:0] mod_cnt; // mode update countdown
		logic [1:0]  rtt_pend;   // pending strength
		logic [CNT_W-1:0] oit_cnt; // test driver countdown
		logic        oit;        // test driver state
		logic        pd_req;     // control value seen in power-down
		logic [CNT_W-1:0] pd_cnt; // power-down response wait, counting up
		logic [1:0]  out_rtt;    // strength on the link
	} dev_s;
	dev_s st, next_st;

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		next_st = st;
		if (link.cke) begin
			// shift sampled control; turn-off path one step longer
			next_st.pipe = {st.pipe[3:0], link.termination_control};
			if (st.pipe[TERM_ON_DELAY_CK-1] && link.termination_control)
				next_st.on = 1'b1;
			// 2.5 clocks rounds to the third edge at 0.5 high phase
			if (!st.pipe[TERM_OFF_DELAY_HALF/2] && !st.pipe[1] && !st.pipe[0])
				next_st.on = 1'b0;
			if (st.pipe[TERM_ON_DELAY_CK-1] && st.pipe[0])
				next_st.on = 1'b1;
			next_st.pd_cnt = '0;
			// keep the power-down copy current so entry never compares a stale level
			next_st.pd_req = link.termination_control;
		end else begin
			// power-down: respond without the pipeline after a fixed wait
			next_st.pd_req = link.termination_control;
			if (st.pd_req != st.on) begin
				if (st.pd_cnt >= CNT_W'(PD_MIN_CK)) begin
					next_st.on = st.pd_req;
					next_st.pd_cnt = '0;
				end else
					next_st.pd_cnt = st.pd_cnt + 1'b1;
			end else
				next_st.pd_cnt = '0;
			next_st.pipe = {5{link.termination_control}};
		end
		// mode register commands
		// a one-cycle update applies at the command edge, inside the 12 ns limit
		if (link.cmd == CMD_EXT) begin
			next_st.rtt_pend = rtt_decode(link.addr);
			next_st.mod_cnt = CNT_W'(MODE_UPDATE_CK - 1);
			if (MODE_UPDATE_CK == 1)
				next_st.rtt = rtt_decode(link.addr);
		end else if (st.mod_cnt != '0) begin
			next_st.mod_cnt = st.mod_cnt - 1'b1;
			if (st.mod_cnt == 8'h01)
				next_st.rtt = st.rtt_pend;
		end
		if (link.cmd == CMD_MODE)
			next_st.slow = link.addr[MODE_EXIT_SEL_BIT];
		if (link.cmd == CMD_IMP_TEST) begin
			next_st.oit_cnt = CNT_W'(IMP_TEST_CK - 1);
			if (IMP_TEST_CK == 1)
				next_st.oit = 1'b1;
		end else if (st.oit_cnt != '0) begin
			next_st.oit_cnt = st.oit_cnt - 1'b1;
			if (st.oit_cnt == 8'h01)
				next_st.oit = 1'b1;
		end
		next_st.out_rtt = next_st.on ? next_st.rtt : RTT_OFF;
		if (sys_rst) begin
			next_st = '0;
		end
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign link.rtt_active     = st.out_rtt;
	assign link.imp_test_drive = st.oit;
	assign rtt_setting         = st.rtt;
	assign slow_exit           = st.slow;
	assign term_on             = st.on;
endmodule

// >>> term_controller.sv
// Purpose: controller end, spacing of termination and commands
// Assumes: user requests arrive on the same clock
// Notes:   one request at a time, busy follows the spacing counters one cycle late
`timescale 1ns/100ps
module term_controller
	import term_timing_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            sys_rst,
	term_link_if.controller      link,
	input  wire logic            req_valid,    // user request strobe
	input  wire logic [2:0]      req_cmd,      // command code
	input  wire logic [ADDR_W-1:0] req_addr,   // address
	input  wire logic            req_term,     // wanted termination level
	input  wire logic            req_pd,       // want power-down
	input  wire logic [3:0]      wr_recovery,  // programmed write recovery
	input  wire logic [3:0]      precharge_ck, // precharge time in clocks, rounded up
	input  wire logic [2:0]      additive_latency_setting,
	output logic                 busy,         // request not taken
	output logic                 in_pd         // link in power-down
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		logic             cke;
		logic             term;
		logic [2:0]       cmd;
		logic [ADDR_W-1:0] addr;
		logic [CNT_W-1:0] stable;    // cycles control unchanged
		logic [CNT_W-1:0] gap;       // command spacing countdown
		logic [CNT_W-1:0] rd_gap;    // read spacing countdown
		logic [CNT_W-1:0] exit_cnt;  // cycles since power-down exit
		logic             slow;      // slow exit programmed
		logic             cke_hold;  // clock kept after enable drop
		logic             busy;
	} ctl_s;
	ctl_s st, next_st;

	logic [CNT_W-1:0] slow_wait;
	assign slow_wait = CNT_W'(SLOW_EXIT_BASE_CK) - CNT_W'(additive_latency_setting);

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		next_st = st;
		next_st.cmd = CMD_NOP;
		if (st.gap != '0) next_st.gap = st.gap - 1'b1;
		if (st.rd_gap != '0) next_st.rd_gap = st.rd_gap - 1'b1;
		if (st.stable != 8'hff) next_st.stable = st.stable + 1'b1;
		if (st.exit_cnt != 8'hff && st.cke) next_st.exit_cnt = st.exit_cnt + 1'b1;
		next_st.cke_hold = 1'b0;
		// termination change only when settled after power-down exit
		if (req_term != st.term && st.cke && st.exit_cnt >= CNT_W'(TERM_PD_EXIT_CK)) begin
			next_st.term = req_term;
			next_st.stable = '0;
		end
		// no entry in the cycle the control level moves, or the stable count would lie
		if (req_pd && st.cke && st.stable >= CNT_W'(TERM_TO_PD_ENTRY_CK) && st.gap == '0 && req_term == st.term)
			next_st.cke = 1'b0;
		else if (!req_pd && !st.cke) begin
			next_st.cke = 1'b1;
			next_st.exit_cnt = '0;
			next_st.rd_gap = st.slow ? slow_wait : CNT_W'(FAST_EXIT_READ_CK);
		end
		next_st.busy = !(st.cke && st.gap == '0 && !(req_cmd == CMD_READ && st.rd_gap != '0));
		if (req_valid && !st.busy && st.cke && !(req_cmd == CMD_READ && st.rd_gap != '0)) begin
			next_st.cmd = req_cmd;
			next_st.addr = req_addr;
			case (req_cmd)
				CMD_MODE: next_st.slow = req_addr[MODE_EXIT_SEL_BIT];
				CMD_WRITE_AP: next_st.gap = CNT_W'(wr_recovery) + CNT_W'(precharge_ck);
				CMD_WRITE: next_st.rd_gap = CNT_W'(WRITE_TO_READ_CK) + 8'h01;
				default: next_st.gap = st.gap;
			endcase
		end
		if (sys_rst) begin
			next_st = '0;
			next_st.cke = 1'b1;
			next_st.exit_cnt = 8'hff;
			next_st.busy = 1'b1;
		end
	end

	// ---------------------------------------------
	// registers; clock never stops here, which covers the hold after cke drop
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign link.cke = st.cke;
	assign link.termination_control = st.term;
	assign link.cmd = st.cmd;
	assign link.addr = st.addr;
	assign busy = st.busy;
	assign in_pd = !st.cke;
endmodule

// >>> term_link_chk.sv
// Purpose: watch the termination link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   strength mirrored from extension writes
`timescale 1ns/100ps
module term_link_chk
	import term_timing_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              cke,
	input wire logic              termination_control,
	input wire logic [2:0]        cmd,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0]        rtt_active,
	input wire logic              imp_test_drive
);
	// ---------------------------------------------
	// helper
	// ---------------------------------------------
	logic [1:0] exp_rtt; // last strength written
	// mirror of the programmed strength, kept apart from the device
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exp_rtt <= RTT_OFF;
		end else if (cmd == CMD_EXT) begin
			exp_rtt <= {addr[EXT_RTT_HI_BIT], addr[EXT_RTT_LO_BIT]};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	sequence s_on_req;
		$rose(termination_control) && cke;
	endsequence
	sequence s_off_req;
		$fell(termination_control) && cke;
	endsequence
	// on edge differs from off edge by half a cycle rounded up
	a_term_on_delay: assert property (s_on_req |-> ##1 rtt_active == RTT_OFF ##[1:2] rtt_active == exp_rtt)
		else $error("termination on delay wrong");
	a_term_off_delay: assert property (s_off_req |-> ##2 rtt_active == exp_rtt ##[1:2] rtt_active == RTT_OFF)
		else $error("termination off delay wrong");
	a_pd_entry_stable: assert property ($fell(cke) |-> $stable(termination_control) &&
		$past(termination_control, 2) == termination_control && $past(termination_control, 3) == termination_control)
		else $error("control moved before power-down");
	a_pd_exit_hold: assert property ($rose(cke) |-> $stable(termination_control)[*8])
		else $error("control moved soon after power-down exit");
	a_mode_strength: assert property (cmd == CMD_EXT && cke && termination_control && $past(termination_control, 3)
		|=> rtt_active == exp_rtt)
		else $error("new strength not applied");
	a_imp_test_drive: assert property (cmd == CMD_IMP_TEST |=> imp_test_drive)
		else $error("test driver not applied");
	a_imp_cause: assert property ($rose(imp_test_drive) |-> $past(cmd) == CMD_IMP_TEST)
		else $error("test driver without command");
	a_write_read_gap: assert property (cmd == CMD_WRITE |=> (cmd != CMD_READ)[*2])
		else $error("read too close to write");
	a_write_ap_gap: assert property (cmd == CMD_WRITE_AP |=> (cmd == CMD_NOP)[*3])
		else $error("command too close to auto-precharge write");
	a_exit_read_gap: assert property ($rose(cke) |-> (cmd != CMD_READ)[*2])
		else $error("read too close to power-down exit");
endmodule

// >>> dram_odt_powerdown_timing_test.sv
// Purpose: drive both ends through termination and spacing cases
// Assumes: a taken command shows on the link in the next cycle
// Notes:   fine edge timing is judged by the link checker
`timescale 1ns/100ps
module dram_odt_powerdown_timing_test;
	import term_timing_pkg::*;
	logic              clk, sys_rst, req_valid, req_term, req_pd;
	logic              busy, in_pd, slow_exit, term_on, cke_q;
	logic [2:0]        req_cmd;
	logic [ADDR_W-1:0] req_addr;
	logic [1:0]        rtt_setting;
	int                err_total, num_checks, cyc, cmd_at, prev_at, up_at;
	// ---------------------------------------------
	// ends, link and checker
	// ---------------------------------------------
	term_link_if link ();
	term_device i_term_device (.clk(clk), .sys_rst(sys_rst), .link(link), .rtt_setting(rtt_setting),
		.slow_exit(slow_exit), .term_on(term_on));
	term_controller i_term_controller (.clk(clk), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_term(req_term), .req_pd(req_pd), .wr_recovery(4'h2),
		.precharge_ck(4'h2), .additive_latency_setting(3'h0), .busy(busy), .in_pd(in_pd));
	term_link_chk i_term_link_chk (.clk(clk), .sys_rst(sys_rst), .cke(link.cke), .cmd(link.cmd), .addr(link.addr),
		.termination_control(link.termination_control), .rtt_active(link.rtt_active), .imp_test_drive(link.imp_test_drive));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// cycle count, command stamps and hang guard
	always @(posedge clk) begin
		cyc++;
		if (link.cmd !== CMD_NOP) begin
			prev_at = cmd_at;
			cmd_at = cyc;
		end
		if (link.cke === 1'b1 && cke_q === 1'b0) up_at = cyc;
		cke_q = link.cke;
		if (cyc > 4000) begin
			err_total++;
			stop_test();
		end
	end
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// request only while not busy, so a taken command is never sent twice
	task automatic issue(input logic [2:0] c, input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		req_cmd = c;
		req_addr = a;
		while (n < 50 && link.cmd !== c) begin
			req_valid = (busy === 1'b0);
			@(negedge clk);
			n++;
		end
		req_valid = 1'b0;
		// let the stamp edge pass so callers see this command's cycle
		wait_ck(1);
		check("command taken", 16'(n < 50), 16'h1);
	endtask
	task automatic wait_ck(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_strength();
		logic [ADDR_W-1:0] a;
		for (int k = 1; k < 4; k++) begin
			a = '0;
			a[EXT_RTT_HI_BIT] = k[1];
			a[EXT_RTT_LO_BIT] = k[0];
			issue(CMD_EXT, a);
			req_term = 1'b1;
			wait_ck(10);
			check("strength", 16'(rtt_setting), 16'(k));
			check("applied", 16'(link.rtt_active), 16'(k));
			req_term = 1'b0;
			wait_ck(10);
			check("released", 16'(link.rtt_active), 16'h0);
		end
		// rewrite strength while termination is on: new value within one cycle
		req_term = 1'b1;
		wait_ck(10);
		a = '0;
		a[EXT_RTT_LO_BIT] = 1'b1;
		issue(CMD_EXT, a);
		check("live update", 16'(link.rtt_active), 16'(RTT_75));
		req_term = 1'b0;
		wait_ck(10);
	endtask
	task automatic t_imp_test();
		check("driver idle", 16'(link.imp_test_drive), 16'h0);
		issue(CMD_IMP_TEST, '0);
		check("driver on", 16'(link.imp_test_drive), 16'h1);
	endtask
	task automatic t_spacing();
		issue(CMD_WRITE, '0);
		issue(CMD_READ, '0);
		check("write read gap", 16'(cmd_at - prev_at >= 3), 16'h1);
		issue(CMD_WRITE_AP, '0);
		issue(CMD_WRITE, '0);
		check("autoprecharge gap", 16'(cmd_at - prev_at >= 4), 16'h1);
	endtask
	// slow and fast exit, termination held across power-down
	task automatic t_power_down();
		for (int s = 0; s < 2; s++) begin
			issue(CMD_MODE, 13'(s) << MODE_EXIT_SEL_BIT);
			check("exit select", 16'(slow_exit), 16'(s));
			req_term = 1'b1;
			wait_ck(10);
			req_pd = 1'b1;
			wait_ck(10);
			check("in power-down", 16'({in_pd, link.cke}), 16'h2);
			check("term held", 16'(term_on), 16'h1);
			req_pd = 1'b0;
			issue(CMD_READ, '0);
			check("exit read gap", 16'(cmd_at - up_at >= (s ? 8 : 2)), 16'h1);
			wait_ck(10);
			req_term = 1'b0;
			wait_ck(10);
			check("term off", 16'(term_on), 16'h0);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		{sys_rst, req_valid, req_term, req_pd} = 4'h8;
		req_cmd = CMD_NOP;
		req_addr = '0;
		wait_ck(3);
		sys_rst = 1'b0;
		wait_ck(2);
		t_strength();
		t_imp_test();
		t_spacing();
		t_power_down();
		stop_test();
	end
endmodule
